// [hw/demod_delay_line.sv]
// Tapped shift line delaying the demodulation signal
`timescale 1ns/1ps
`default_nettype none

module demod_delay_line #(
   parameter int DW    = vpc_pkg::DEMOD_W,
   parameter int DEPTH = 256
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          modIn,
   input  wire logic [DW-1:0] delay,
   output var  logic          modOut,
   output var  logic          demodOut
);

   if (DEPTH != (1 << DW) || DW < 1) begin : g_chk
      $error("demod_delay_line: DEPTH must be 2**DW");
   end

   typedef struct packed {
      logic [DEPTH-2:0] line;   // line[k] holds input from k+1 cycles ago
      logic             mod;    // Reference copy, one flop late
      logic             demod;  // Selected tap
   } dly_state_t;

   dly_state_t st;
   dly_state_t next_st;

   // Both outputs pass one flop, so their skew is exactly the delay
   always_comb begin
      next_st      = st;
      next_st.line = {st.line[DEPTH-3:0], modIn};
      next_st.mod  = modIn;
      if (delay == '0)
         next_st.demod = modIn;
      else
         next_st.demod = st.line[delay - 1'b1];
   end

   // Single state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         st <= '0;
      else
         st <= next_st;
   end

   assign modOut   = st.mod;
   assign demodOut = st.demod;

endmodule : demod_delay_line
`default_nettype wire

// [hw/pixel_clock_div.sv]
// Integer divider producing the pixel clock and data launch strobe
`timescale 1ns/1ps
`default_nettype none

module pixel_clock_div #(
   parameter int DW    = vpc_pkg::DIV_W,
   parameter int SKEWN = vpc_pkg::SKEW_CYCLES
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic [DW-1:0] divIn,
   input  wire logic          skewEn,
   output var  logic          pixelClock,
   output var  logic          launch,
   output var  logic [DW-1:0] activeDiv
);

   if (DW != vpc_pkg::DIV_W || SKEWN < 1) begin : g_chk
      $error("pixel_clock_div: unsupported parameters");
   end

   typedef struct packed {
      logic [DW-1:0]    cnt;      // Position in the pixel period
      logic [DW-1:0]    div;      // Divider in force this period
      logic             raw;      // Centred clock before skew
      logic [SKEWN-1:0] line;     // Skew delay stages
      logic             out;      // Pin level
      logic             launch;   // Data change strobe
   } div_state_t;

   div_state_t st;
   div_state_t next_st;
   logic [DW:0] halfN;           // Rising point of next period

   // New divider taken only at a period boundary, so no runt pulse
   always_comb begin
      next_st = st;
      if (st.cnt == st.div) begin
         next_st.cnt = '0;
         next_st.div = divIn;
      end else begin
         next_st.cnt = st.cnt + 1'b1;
      end
      halfN = ({1'b0, next_st.div} + 1'b1) >> 1;
      // Divide by one cannot leave a flop; it toggles at half rate
      if (next_st.div == '0)
         next_st.raw = ~st.raw;
      else
         next_st.raw = ({1'b0, next_st.cnt} >= halfN);
      // Strobe one flop behind the counter, in step with the pin flop,
      // so the unskewed edge sits half a period after the data change
      next_st.launch = (st.cnt == '0);
      next_st.line   = SKEWN'({st.line, st.raw});
      next_st.out    = skewEn ? st.line[SKEWN-1] : st.raw;
   end

   // Single state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st     <= '0;
         st.div <= vpc_pkg::DIV_RST;
      end else begin
         st <= next_st;
      end
   end

   assign pixelClock = st.out;
   assign launch     = st.launch;
   assign activeDiv  = st.div;

   // Helper: cycles between rising edges with an unchanged divider
   logic          rawPrev;
   logic [DW:0]   gap;
   logic          armed;
   logic          sameDiv;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rawPrev <= 1'b0;
         gap     <= '0;
         armed   <= 1'b0;
         sameDiv <= 1'b0;
      end else begin
         rawPrev <= st.raw;
         if (st.raw && !rawPrev) begin
            gap     <= (DW+1)'(1);
            armed   <= 1'b1;
            // At divide by two the boundary falls on the rising edge itself
            sameDiv <= (next_st.div == st.div);
         end else begin
            gap     <= gap + 1'b1;
            sameDiv <= sameDiv & (next_st.div == st.div);
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   chk_period_len: assert property (
      (st.raw && !rawPrev && armed && sameDiv && st.div != '0)
      |-> gap == {1'b0, st.div} + 1'b1)
      else $error("pixel clock period differs from divider+1");

   chk_edge_centre: assert property (
      (st.raw && !rawPrev && st.div != '0)
      |-> {1'b0, st.cnt} == (({1'b0, st.div} + 1'b1) >> 1))
      else $error("pixel clock edge not at period centre");

   chk_skew_delay: assert property (
      $past(skewEn) |-> st.out == $past(st.raw, 1 + SKEWN))
      else $error("skewed pixel clock has wrong delay");

   chk_noskew_delay: assert property (
      !$past(skewEn) |-> st.out == $past(st.raw))
      else $error("unskewed pixel clock has extra delay");

endmodule : pixel_clock_div
`default_nettype wire

// [hw/video_port_clock_ctrl.sv]
// Video port pixel clock and demodulation phase control with APB registers
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module video_port_clock_ctrl (
   input  wire logic        clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Modulation reference from same clock
   input  wire logic        modRef,
   output var  logic        modOut,
   output var  logic        demodOut,
   // Camera video port clocking
   output var  logic        pixelClockOut,
   output var  logic        pixelLaunch
);

   // Register and bus state
   typedef struct packed {
      logic [7:0]  clkCfg;      // Divider and skew enable
      logic [7:0]  demodDelay;  // Demodulation lag in clocks
      logic [31:0] rdData;      // Read data held for the answer
      logic        ready;       // Answer cycle flag
      logic        slvErr;      // Unmapped address flag
   } ctrl_state_t;

   ctrl_state_t st;
   ctrl_state_t next_st;

   // Bus phase decode
   logic accessFirst;   // First access cycle, answer prepared
   logic accessDone;    // Completion edge, write lands here
   logic hitCfg;
   logic hitDemod;
   logic hitStatus;

   assign accessFirst = psel & penable & ~st.ready;
   assign accessDone  = psel & penable & st.ready;

   // Full address compare; aliases would hide software bugs
   assign hitCfg    = (paddr == vpc_pkg::OFF_CLKCFG);
   assign hitDemod  = (paddr == vpc_pkg::OFF_DEMOD);
   assign hitStatus = (paddr == vpc_pkg::OFF_STATUS);

   // Divider outputs
   logic [vpc_pkg::DIV_W-1:0] activeDiv;   // Divider now in force
   logic [15:0]                statusWord; // Live block state

   // Pixel clock generator
   pixel_clock_div #(
      .DW    (vpc_pkg::DIV_W),
      .SKEWN (vpc_pkg::SKEW_CYCLES)
   ) u_div (
      .clk        (clk),
      .rst        (rst),
      .divIn      (st.clkCfg[vpc_pkg::DIV_LSB +: vpc_pkg::DIV_W]),
      .skewEn     (st.clkCfg[vpc_pkg::SKEW_BIT]),
      .pixelClock (pixelClockOut),
      .launch     (pixelLaunch),
      .activeDiv  (activeDiv)
   );

   // Demodulation phase delay
   demod_delay_line #(
      .DW    (vpc_pkg::DEMOD_W),
      .DEPTH (256)
   ) u_dly (
      .clk      (clk),
      .rst      (rst),
      .modIn    (modRef),
      .delay    (st.demodDelay),
      .modOut   (modOut),
      .demodOut (demodOut)
   );

   // Status view of the running logic
   always_comb begin
      statusWord = '0;
      statusWord[vpc_pkg::STAT_PCLK_BIT]  = pixelClockOut;
      statusWord[vpc_pkg::STAT_DEMOD_BIT] = demodOut;
      statusWord[vpc_pkg::STAT_DIV_LSB +: vpc_pkg::DIV_W] = activeDiv;
   end

   // Register file and bus answer
   // One wait state: data is registered in the first access cycle
   always_comb begin
      next_st        = st;
      next_st.ready  = 1'b0;
      next_st.slvErr = 1'b0;
      next_st.rdData = '0;

      // Prepare the answer
      if (accessFirst) begin
         next_st.ready = 1'b1;
         if (hitCfg) begin
            // Reserved bits come back as zero
            next_st.rdData = 32'(st.clkCfg);
         end else if (hitDemod) begin
            next_st.rdData = 32'(st.demodDelay);
         end else if (hitStatus) begin
            next_st.rdData = 32'(statusWord);
         end else begin
            // Unmapped: error, zero data
            next_st.slvErr = 1'b1;
         end
      end

      // Writes take effect only at the completion edge
      if (accessDone && pwrite) begin
         if (hitCfg) begin
            // Reserved bits are dropped whatever is written
            next_st.clkCfg = pwdata[7:0] & vpc_pkg::CLKCFG_MASK;
         end else if (hitDemod) begin
            next_st.demodDelay = pwdata[vpc_pkg::DEMOD_W-1:0];
         end else begin
            // Status is read only; others already errored
            next_st.demodDelay = st.demodDelay;
         end
      end

      // Hold the answer through the completion cycle only
      if (accessDone) begin
         next_st.ready = 1'b0;
      end
   end

   // Single state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st            <= '0;
         st.clkCfg     <= vpc_pkg::CLKCFG_RST;
         st.demodDelay <= vpc_pkg::DEMOD_RST;
      end else begin
         st <= next_st;
      end
   end

   // Bus outputs straight from flops
   assign prdata  = st.rdData;
   assign pready  = st.ready;
   assign pslverr = st.slvErr;

   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // After release the divider reads back three and is in force
   chk_div_reset: assert property (
      $fell(rst) |-> (st.clkCfg == vpc_pkg::CLKCFG_RST) &&
                     (activeDiv == vpc_pkg::DIV_RST))
      else $error("divider not at reset value after reset");

   // Zero delay: demodulation follows modulation exactly
   chk_demod_zero: assert property (
      ($past(st.demodDelay) == 8'h00) |-> demodOut == modOut)
      else $error("demodulation lag wrong at zero delay");

   // One period of lag
   chk_demod_one: assert property (
      ($past(st.demodDelay) == 8'h01) |-> demodOut == $past(modOut))
      else $error("demodulation lag wrong at one period");

   // Three periods of lag
   chk_demod_three: assert property (
      ($past(st.demodDelay) == 8'h03) |-> demodOut == $past(modOut, 3))
      else $error("demodulation lag wrong at three periods");

   // Answer lasts exactly one cycle, one cycle after access begins
   chk_apb_answer: assert property (
      (psel && penable && !pready) |=> pready ##1 !pready)
      else $error("bus answer timing wrong");

   // A written divider reaches the generator within one period
   chk_div_apply: assert property (
      (accessDone && pwrite && hitCfg)
      |=> ##[0:33] (activeDiv == st.clkCfg[vpc_pkg::DIV_LSB +: vpc_pkg::DIV_W]))
      else $error("divider write never applied");

endmodule : video_port_clock_ctrl
`default_nettype wire

// [hw/vpc_pkg.sv]
// Shared constants for the video port clock and demodulation phase block
package vpc_pkg;

   // Clock period and the skew step, in picoseconds
   localparam int CLK_PERIOD_PS = 40000;
   localparam int SKEW_PS       = 2000;
   // Least time rounds up, never below one cycle
   localparam int SKEW_RAW      = (SKEW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SKEW_CYCLES   = (SKEW_RAW < 1) ? 1 : SKEW_RAW;

   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] OFF_CLKCFG = 8'h00;
   localparam logic [7:0] OFF_DEMOD  = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;

   // Clock configuration layout
   localparam int         DIV_LSB     = 0;
   localparam int         DIV_W       = 5;
   localparam int         SKEW_BIT    = 7;
   localparam logic [7:0] CLKCFG_MASK = 8'h9F;
   localparam logic [7:0] CLKCFG_RST  = 8'h03;
   localparam logic [4:0] DIV_RST     = 5'h03;

   // Demodulation delay register
   localparam int         DEMOD_W   = 8;
   localparam logic [7:0] DEMOD_RST = 8'h00;

   // Status word layout
   localparam int STAT_PCLK_BIT  = 0;
   localparam int STAT_DEMOD_BIT = 1;
   localparam int STAT_DIV_LSB   = 8;

endpackage : vpc_pkg

// [verif/pixel_capture_model.sv]
// Host capture model measuring pixel clock period and edge placement
`timescale 1ns/1ps
`default_nettype none

module pixel_capture_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       pixelClockOut,
   input  wire logic       pixelLaunch,
   output var  logic [7:0] period,
   output var  logic [7:0] riseAt
);
   logic [7:0] cnt;     // Cycles since last launch
   logic       prevClk; // Last sampled pixel clock

   // Host sees only the pins, so timing is judged as a capture flop would
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt     <= 8'h00;
         prevClk <= 1'b0;
         period  <= 8'h00;
         riseAt  <= 8'h00;
      end else begin
         prevClk <= pixelClockOut;
         // Rising edge offset from launch
         if (pixelClockOut && !prevClk) begin
            riseAt <= cnt;
         end
         // Launch closes one period
         if (pixelLaunch) begin
            period <= cnt;
            cnt    <= 8'h01;
         end else begin
            cnt <= cnt + 8'h01;
         end
      end
   end
endmodule : pixel_capture_model

`default_nettype wire

// [verif/video_port_clock_ctrl_tb.sv]
// Self-checking bench for the video port clock block
`timescale 1ns/1ps
`default_nettype none

module video_port_clock_ctrl_tb;
   logic         clk, rst, psel, penable, pwrite, modRef;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic         pready, pslverr, modOut, demodOut, pixelClockOut, pixelLaunch, err;
   logic [7:0]   period, riseAt, d;
   logic [4:0]   dv;
   logic [257:0] hist;           // Recent modRef samples, newest at bit 0
   int           num_errors = 0;
   int           tests_run  = 0;
   logic [31:0]  seed = 32'h0001_5F5C;

   video_port_clock_ctrl uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .modRef(modRef), .modOut(modOut), .demodOut(demodOut),
      .pixelClockOut(pixelClockOut), .pixelLaunch(pixelLaunch));
   pixel_capture_model host (.clk(clk), .rst(rst), .pixelClockOut(pixelClockOut),
      .pixelLaunch(pixelLaunch), .period(period), .riseAt(riseAt));

   // Xorshift source, fixed start so runs repeat
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Expected rising edge offset from launch, plus one cycle when skewed
   function automatic logic [31:0] expRise(logic [4:0] v, logic s);
      return 32'((6'(v) + 6'h01) >> 1) + 32'(s);
   endfunction : expRise

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Random modulation reference and its history
   always @(posedge clk) begin
      modRef <= 1'(rnd());
      hist   <= {hist[256:0], modRef};
   end

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("Checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   // One APB transfer; waits on pready, never on a fixed count
   task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rd  = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n == 20) begin
         num_errors++;
         finish_test();
      end
   endtask : apb

   // Wait for three launches so the new divider has a full period
   task automatic waitLaunch();
      int n, k;
      k = 0;
      for (n = 0; n < 200 && k < 3; n++) begin
         @(posedge clk);
         if (pixelLaunch === 1'b1) k++;
      end
      #1;
      if (k < 3) begin
         num_errors++;
         finish_test();
      end
   endtask : waitLaunch

   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0000_0000; modRef = 1'b0; hist = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Reset values and reset rate
      apb(1'b0, vpc_pkg::OFF_CLKCFG, 32'h0000_0000);
      check("clkcfg reset", rd, 32'h0000_0003);
      apb(1'b0, vpc_pkg::OFF_DEMOD, 32'h0000_0000);
      check("demod reset", rd, 32'h0000_0000);
      waitLaunch();
      check("reset period", 32'(period), 32'h0000_0004);
      $display("test reset done");
      // Divider corners then random, skew alternating, reserved written zero
      for (int i = 0; i < 8; i++) begin
         dv = (i == 0) ? 5'h01 : (i == 1) ? 5'h1F : 5'(rnd() % 31 + 1);
         apb(1'b1, vpc_pkg::OFF_CLKCFG, {24'h0, i[0], 2'b00, dv});
         apb(1'b0, vpc_pkg::OFF_CLKCFG, 32'h0000_0000);
         check("clkcfg readback", rd, {24'h0, i[0], 2'b00, dv});
         check("clkcfg err", 32'(err), 32'h0000_0000);
         waitLaunch();
         check("period", 32'(period), 32'(dv) + 32'h1);
         check("rise offset", 32'(riseAt), expRise(dv, i[0]));
      end
      $display("test divider done");
      // Demodulation lag, ends and random
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : (i == 2) ? 8'h01 :
             (i == 3) ? 8'h03 : 8'(rnd());
         apb(1'b1, vpc_pkg::OFF_DEMOD, {24'h0, d});
         repeat (int'(d) + 4) @(posedge clk);
         for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            #1;
            check("mod out", 32'(modOut), 32'(hist[0]));
            check("demod lag", 32'(demodOut), 32'(hist[d]));
         end
      end
      $display("test demod done");
      // Status shows the divider in force, last one written
      apb(1'b0, vpc_pkg::OFF_STATUS, 32'h0000_0000);
      check("status div", rd & 32'h0000_1F00, {19'h0, dv, 8'h00});
      check("status err", 32'(err), 32'h0000_0000);
      $display("test status done");
      // Unmapped address answers with an error
      apb(1'b0, 8'h0C, 32'h0000_0000);
      check("unmapped err", 32'(err), 32'h0000_0001);
      check("unmapped data", rd, 32'h0000_0000);
      $display("test unmapped done");
      finish_test();
   end
endmodule : video_port_clock_ctrl_tb

`default_nettype wire
